// ### hw/haptic_regs_pkg.sv
// Constants, field layouts and carrier types of the haptic tracking, trim and fault registers.
// Functional notes
// - Read-only 15-bit measured resonant period, split high/low.
// - Autoscale bit scales tracking proportional gain.
// - Force bit keeps tracking despite large error.
// - Two-bit undervoltage lockout threshold, resets 2.8 V.
// - Low/high side slew fields, reset code three.
// - Hold bit pauses estimate updates on reversal.
// - Offset enable adds 50 mV, set at reset.
// - Delay comparator bypass bit, resets zero.
// - Saturation event sticky until write-one clear.
// - Status bit seven shows live saturation.
// - Saturation mask bit seven, resets zero.
// - Snippet bytes consecutive, read-write, reset zero.
// - Loop current DAC double range bit.
// - Loop filter narrow bandwidth bit.
// - Capacitor trim resets three, resistor trim zero.
package haptic_regs_pkg;

	// ************************************************
	// Register offsets
	// ************************************************
	localparam logic [7:0] OFS_PERIOD_HIGH = 8'h46;
	localparam logic [7:0] OFS_PERIOD_LOW = 8'h47;
	localparam logic [7:0] OFS_PHASE_HIGH = 8'h48;
	localparam logic [7:0] OFS_PHASE_LOW = 8'h49;
	localparam logic [7:0] OFS_TRACK_CTL = 8'h4c;
	localparam logic [7:0] OFS_LOOP_LOCKOUT = 8'h5f;
	localparam logic [7:0] OFS_LOOP_FILTER = 8'h60;
	localparam logic [7:0] OFS_BRIDGE_SLEW = 8'h62;
	localparam logic [7:0] OFS_TOP_MISC = 8'h6e;
	localparam logic [7:0] OFS_FAULT_EVENT = 8'h81;
	localparam logic [7:0] OFS_FAULT_STATUS2 = 8'h82;
	localparam logic [7:0] OFS_FAULT_MASK2 = 8'h83;
	localparam logic [7:0] OFS_SNIPPET_FIRST = 8'h84;
	localparam logic [7:0] OFS_SNIPPET_LAST = 8'he7;

	// ************************************************
	// Snippet memory geometry
	// ************************************************
	localparam int SNIPPET_DEPTH = 100;
	localparam int SNIPPET_IDX_W = 7;
	localparam logic [7:0] SNIPPET_RESET = 8'h00;

	// ************************************************
	// Reset values
	// ************************************************
	localparam logic [7:0] RST_PERIOD_HIGH = 8'h21;
	localparam logic [6:0] RST_PERIOD_LOW = 7'h4f;
	localparam logic [7:0] RST_PHASE_HIGH = 8'h25;
	localparam logic RST_PHASE_FREEZE = 1'b0;
	localparam logic [2:0] RST_PHASE_SHIFT = 3'h5;
	localparam logic RST_AUTOSCALE = 1'b1;
	localparam logic RST_FORCE_ON = 1'b0;
	localparam logic RST_DAC_WIDE = 1'b0;
	localparam logic RST_FILTER_NARROW = 1'b0;
	localparam logic [1:0] RST_UVLO_LEVEL = 2'h1;
	localparam logic [1:0] RST_CAP_ADJUST = 2'h3;
	localparam logic [1:0] RST_RES_ADJUST = 2'h0;
	localparam logic [1:0] RST_SLEW = 2'h3;
	localparam logic RST_DELAY_BYPASS = 1'b0;
	localparam logic RST_HOLD_ON_REVERSAL = 1'b0;
	localparam logic RST_OFFSET_ENABLE = 1'b1;
	localparam logic RST_SAT_MASK = 1'b0;

	// ************************************************
	// Field positions
	// ************************************************
	localparam int BIT_PHASE_FREEZE = 7;
	localparam int BIT_AUTOSCALE = 1;
	localparam int BIT_FORCE_ON = 0;
	localparam int BIT_DAC_WIDE = 6;
	localparam int BIT_FILTER_NARROW = 5;
	localparam int BIT_UVLO_LSB = 3;
	localparam int BIT_CAP_LSB = 2;
	localparam int BIT_RES_LSB = 0;
	localparam int BIT_LOW_SLEW_LSB = 2;
	localparam int BIT_HIGH_SLEW_LSB = 0;
	localparam int BIT_DELAY_BYPASS = 2;
	localparam int BIT_HOLD_REVERSAL = 1;
	localparam int BIT_OFFSET_ENABLE = 0;
	localparam int BIT_SAT_EVENT = 2;
	localparam int BIT_SAT_STATUS = 7;
	localparam int BIT_SAT_MASK = 7;

	// ************************************************
	// Carrier types
	// ************************************************
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wrData;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic [7:0] phaseHigh;
		logic phaseFreeze;
		logic [2:0] phaseShift;
		logic trackingGainAutoscale;
		logic trackingForceActive;
		logic loopCurrentDacWide;
		logic loopFilterNarrow;
		logic [1:0] undervoltageLockoutLevel;
		logic [1:0] loopCapacitorAdjust;
		logic [1:0] loopResistorAdjust;
		logic [1:0] lowSideSlewSelect;
		logic [1:0] highSideSlewSelect;
		logic delayBypass;
		logic holdUpdateOnReversal;
		logic conversionOffsetEnable;
	} trim_cfg_t;

endpackage

// ### hw/haptic_tracking_trim_fault_regs.sv
// Register bank for period read-back, phase delay, tracking, trims, fault event and snippets.
`timescale 1ns/1ns
module haptic_tracking_trim_fault_regs (
	input wire logic clk,
	input wire logic rst_n,
	input wire haptic_regs_pkg::reg_req_t regReq,
	output logic [7:0] regRdData,
	input wire logic periodValid,
	input wire logic [7:0] periodActualHighPart,
	input wire logic [6:0] periodActualLowPart,
	input wire logic trackingRequest,
	input wire logic trackingErrorLarge,
	input wire logic driveReversal,
	input wire logic converterSaturated,
	output haptic_regs_pkg::trim_cfg_t trimCfg,
	output logic trackingActive,
	output logic frequencyUpdateEnable,
	output logic faultIrq
);
	import haptic_regs_pkg::*;

	// ************************************************
	// Register state
	// ************************************************
	logic [7:0] periodHigh_q;
	logic [6:0] periodLow_q;
	logic [7:0] phaseHigh_q;
	logic phaseFreeze_q;
	logic [2:0] phaseShift_q;
	logic autoscale_q;
	logic forceOn_q;
	logic dacWide_q;
	logic filterNarrow_q;
	logic [1:0] uvloLevel_q;
	logic [1:0] capAdjust_q;
	logic [1:0] resAdjust_q;
	logic [1:0] lowSlew_q;
	logic [1:0] highSlew_q;
	logic delayBypass_q;
	logic holdReversal_q;
	logic offsetEnable_q;
	logic satEvent_q;
	logic satStatus_q;
	logic satMask_q;
	logic [7:0] regRdData_d;
	logic trackingActive_d;
	logic frequencyUpdateEnable_d;

	// ************************************************
	// Address decode
	// ************************************************
	logic inSnippet;
	logic snippetWrite;
	logic [SNIPPET_IDX_W-1:0] snippetIdx;
	logic [7:0] snippetOffset;
	logic [7:0] snippetRdData;
	logic satClear;

	assign inSnippet = (regReq.addr >= OFS_SNIPPET_FIRST) && (regReq.addr <= OFS_SNIPPET_LAST);
	assign snippetOffset = regReq.addr - OFS_SNIPPET_FIRST;
	assign snippetIdx = snippetOffset[SNIPPET_IDX_W-1:0];
	assign snippetWrite = regReq.wr && inSnippet;
	assign satClear = regReq.wr && (regReq.addr == OFS_FAULT_EVENT) &&
		regReq.wrData[BIT_SAT_EVENT];

	// ************************************************
	// Snippet memory
	// ************************************************
	snippet_memory snippet_memory_inst (
		.clk(clk),
		.rst_n(rst_n),
		.wrEn(snippetWrite),
		.wrIdx(snippetIdx),
		.wrData(regReq.wrData),
		.rdIdx(snippetIdx),
		.rdData(snippetRdData)
	);

	// ************************************************
	// Measured period read-back
	// ************************************************
	// Both halves are captured together, but reading the high half does not freeze the low half, so a capture between the two reads gives a torn pair.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			periodHigh_q <= RST_PERIOD_HIGH;
			periodLow_q <= RST_PERIOD_LOW;
		end else if (periodValid) begin
			periodHigh_q <= periodActualHighPart;
			periodLow_q <= periodActualLowPart;
		end
	end

	// ************************************************
	// Phase delay settings
	// ************************************************
	// Reserved encodings are stored as written; keeping to the two legal settings is up to software.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phaseHigh_q <= RST_PHASE_HIGH;
			phaseFreeze_q <= RST_PHASE_FREEZE;
			phaseShift_q <= RST_PHASE_SHIFT;
		end else if (regReq.wr) begin
			if (regReq.addr == OFS_PHASE_HIGH) begin
				phaseHigh_q <= regReq.wrData;
			end
			if (regReq.addr == OFS_PHASE_LOW) begin
				phaseFreeze_q <= regReq.wrData[BIT_PHASE_FREEZE];
				phaseShift_q <= regReq.wrData[2:0];
			end
		end
	end

	// ************************************************
	// Tracking control
	// ************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			autoscale_q <= RST_AUTOSCALE;
			forceOn_q <= RST_FORCE_ON;
		end else if (regReq.wr && (regReq.addr == OFS_TRACK_CTL)) begin
			autoscale_q <= regReq.wrData[BIT_AUTOSCALE];
			forceOn_q <= regReq.wrData[BIT_FORCE_ON];
		end
	end

	// ************************************************
	// Loop and lockout trims
	// ************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dacWide_q <= RST_DAC_WIDE;
			filterNarrow_q <= RST_FILTER_NARROW;
			uvloLevel_q <= RST_UVLO_LEVEL;
		end else if (regReq.wr && (regReq.addr == OFS_LOOP_LOCKOUT)) begin
			dacWide_q <= regReq.wrData[BIT_DAC_WIDE];
			filterNarrow_q <= regReq.wrData[BIT_FILTER_NARROW];
			uvloLevel_q <= regReq.wrData[BIT_UVLO_LSB+:2];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			capAdjust_q <= RST_CAP_ADJUST;
			resAdjust_q <= RST_RES_ADJUST;
		end else if (regReq.wr && (regReq.addr == OFS_LOOP_FILTER)) begin
			capAdjust_q <= regReq.wrData[BIT_CAP_LSB+:2];
			resAdjust_q <= regReq.wrData[BIT_RES_LSB+:2];
		end
	end

	// ************************************************
	// Bridge edge rate
	// ************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lowSlew_q <= RST_SLEW;
			highSlew_q <= RST_SLEW;
		end else if (regReq.wr && (regReq.addr == OFS_BRIDGE_SLEW)) begin
			lowSlew_q <= regReq.wrData[BIT_LOW_SLEW_LSB+:2];
			highSlew_q <= regReq.wrData[BIT_HIGH_SLEW_LSB+:2];
		end
	end

	// ************************************************
	// Top-level miscellaneous configuration
	// ************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			delayBypass_q <= RST_DELAY_BYPASS;
			holdReversal_q <= RST_HOLD_ON_REVERSAL;
			offsetEnable_q <= RST_OFFSET_ENABLE;
		end else if (regReq.wr && (regReq.addr == OFS_TOP_MISC)) begin
			delayBypass_q <= regReq.wrData[BIT_DELAY_BYPASS];
			holdReversal_q <= regReq.wrData[BIT_HOLD_REVERSAL];
			offsetEnable_q <= regReq.wrData[BIT_OFFSET_ENABLE];
		end
	end

	// ************************************************
	// Converter saturation fault
	// ************************************************
	// A saturation seen in the same cycle as the clear wins, so no event is lost.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			satEvent_q <= 1'b0;
		end else if (converterSaturated) begin
			satEvent_q <= 1'b1;
		end else if (satClear) begin
			satEvent_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			satStatus_q <= 1'b0;
		end else begin
			satStatus_q <= converterSaturated;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			satMask_q <= RST_SAT_MASK;
		end else if (regReq.wr && (regReq.addr == OFS_FAULT_MASK2)) begin
			satMask_q <= regReq.wrData[BIT_SAT_MASK];
		end
	end

	// The mask gates only the interrupt; flag and status keep updating underneath it.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			faultIrq <= 1'b0;
		end else begin
			faultIrq <= satEvent_q && !satMask_q;
		end
	end

	// ************************************************
	// Tracking loop steering
	// ************************************************
	always_comb begin
		trackingActive_d = trackingRequest && (!trackingErrorLarge || forceOn_q);
		frequencyUpdateEnable_d = !(holdReversal_q && driveReversal);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			trackingActive <= 1'b0;
			frequencyUpdateEnable <= 1'b1;
		end else begin
			trackingActive <= trackingActive_d;
			frequencyUpdateEnable <= frequencyUpdateEnable_d;
		end
	end

	// ************************************************
	// Configuration outputs
	// ************************************************
	always_comb begin
		trimCfg.phaseHigh = phaseHigh_q;
		trimCfg.phaseFreeze = phaseFreeze_q;
		trimCfg.phaseShift = phaseShift_q;
		trimCfg.trackingGainAutoscale = autoscale_q;
		trimCfg.trackingForceActive = forceOn_q;
		trimCfg.loopCurrentDacWide = dacWide_q;
		trimCfg.loopFilterNarrow = filterNarrow_q;
		trimCfg.undervoltageLockoutLevel = uvloLevel_q;
		trimCfg.loopCapacitorAdjust = capAdjust_q;
		trimCfg.loopResistorAdjust = resAdjust_q;
		trimCfg.lowSideSlewSelect = lowSlew_q;
		trimCfg.highSideSlewSelect = highSlew_q;
		trimCfg.delayBypass = delayBypass_q;
		trimCfg.holdUpdateOnReversal = holdReversal_q;
		trimCfg.conversionOffsetEnable = offsetEnable_q;
	end

	// ************************************************
	// Read-back
	// ************************************************
	// Unmapped addresses and reserved bits read as zero.
	always_comb begin
		regRdData_d = 8'h00;
		if (inSnippet) begin
			regRdData_d = snippetRdData;
		end else begin
			case (regReq.addr)
				OFS_PERIOD_HIGH: begin
					regRdData_d = periodHigh_q;
				end
				OFS_PERIOD_LOW: begin
					regRdData_d = {1'b0, periodLow_q};
				end
				OFS_PHASE_HIGH: begin
					regRdData_d = phaseHigh_q;
				end
				OFS_PHASE_LOW: begin
					regRdData_d[BIT_PHASE_FREEZE] = phaseFreeze_q;
					regRdData_d[2:0] = phaseShift_q;
				end
				OFS_TRACK_CTL: begin
					regRdData_d[BIT_AUTOSCALE] = autoscale_q;
					regRdData_d[BIT_FORCE_ON] = forceOn_q;
				end
				OFS_LOOP_LOCKOUT: begin
					regRdData_d[BIT_DAC_WIDE] = dacWide_q;
					regRdData_d[BIT_FILTER_NARROW] = filterNarrow_q;
					regRdData_d[BIT_UVLO_LSB+:2] = uvloLevel_q;
				end
				OFS_LOOP_FILTER: begin
					regRdData_d[BIT_CAP_LSB+:2] = capAdjust_q;
					regRdData_d[BIT_RES_LSB+:2] = resAdjust_q;
				end
				OFS_BRIDGE_SLEW: begin
					regRdData_d[BIT_LOW_SLEW_LSB+:2] = lowSlew_q;
					regRdData_d[BIT_HIGH_SLEW_LSB+:2] = highSlew_q;
				end
				OFS_TOP_MISC: begin
					regRdData_d[BIT_DELAY_BYPASS] = delayBypass_q;
					regRdData_d[BIT_HOLD_REVERSAL] = holdReversal_q;
					regRdData_d[BIT_OFFSET_ENABLE] = offsetEnable_q;
				end
				OFS_FAULT_EVENT: begin
					regRdData_d[BIT_SAT_EVENT] = satEvent_q;
				end
				OFS_FAULT_STATUS2: begin
					regRdData_d[BIT_SAT_STATUS] = satStatus_q;
				end
				OFS_FAULT_MASK2: begin
					regRdData_d[BIT_SAT_MASK] = satMask_q;
				end
				default: begin
					regRdData_d = 8'h00;
				end
			endcase
		end
	end

	// Read data holds its last value between reads, which keeps a slow serial shifter stable.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			regRdData <= 8'h00;
		end else if (regReq.rd) begin
			regRdData <= regRdData_d;
		end
	end

endmodule

// ### hw/snippet_memory.sv
// Byte array holding the waveform snippet memory window.
`timescale 1ns/1ns
module snippet_memory (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wrEn,
	input wire logic [haptic_regs_pkg::SNIPPET_IDX_W-1:0] wrIdx,
	input wire logic [7:0] wrData,
	input wire logic [haptic_regs_pkg::SNIPPET_IDX_W-1:0] rdIdx,
	output logic [7:0] rdData
);
	import haptic_regs_pkg::*;

	// ************************************************
	// Storage
	// ************************************************
	// Every byte resets to zero, so the array is built from flops rather than a RAM macro.
	logic [7:0] snippetMemoryByte_q [SNIPPET_DEPTH];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < SNIPPET_DEPTH; i++) begin
				snippetMemoryByte_q[i] <= SNIPPET_RESET;
			end
		end else if (wrEn) begin
			snippetMemoryByte_q[wrIdx] <= wrData;
		end
	end

	// Out-of-window addresses can present indices at or above the depth; the caller discards that read data, so no range guard is added here.
	assign rdData = snippetMemoryByte_q[rdIdx];

endmodule

// ### verification/haptic_tracking_trim_fault_regs_props.sv
// Concurrent checks on the ports of the haptic register bank.
`timescale 1ns/1ns
module haptic_tracking_trim_fault_regs_props (
	input wire logic clk,
	input wire logic rst_n,
	input wire haptic_regs_pkg::reg_req_t regReq,
	input wire logic [7:0] regRdData,
	input wire logic periodValid,
	input wire logic [7:0] periodActualHighPart,
	input wire logic [6:0] periodActualLowPart,
	input wire logic trackingRequest,
	input wire logic trackingErrorLarge,
	input wire logic driveReversal,
	input wire logic converterSaturated,
	input wire haptic_regs_pkg::trim_cfg_t trimCfg,
	input wire logic trackingActive,
	input wire logic frequencyUpdateEnable,
	input wire logic faultIrq
);
	import haptic_regs_pkg::*;
	logic maskQ;
	logic clrW;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// The mask is only reachable through the bus, so it is shadowed here.
	assign clrW = regReq.wr && regReq.addr == OFS_FAULT_EVENT && regReq.wrData[BIT_SAT_EVENT];
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			maskQ <= 1'b0;
		end else if (regReq.wr && regReq.addr == OFS_FAULT_MASK2) begin
			maskQ <= regReq.wrData[7];
		end
	end
	property p_track;
		$past(rst_n) |-> trackingActive ==
			$past(trackingRequest && (!trackingErrorLarge || trimCfg.trackingForceActive));
	endproperty
	a_track: assert property (p_track) else $error("tracking active wrong");
	property p_freq;
		$past(rst_n) |-> frequencyUpdateEnable ==
			!$past(trimCfg.holdUpdateOnReversal && driveReversal);
	endproperty
	a_freq: assert property (p_freq) else $error("update enable wrong");
	property p_irq_set;
		converterSaturated ##1 !maskQ |=> faultIrq;
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("irq missing");
	property p_irq_mask;
		maskQ |=> !faultIrq;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("masked irq seen");
	property p_irq_hold;
		faultIrq && !maskQ && !$past(clrW) |=> faultIrq;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("event not sticky");
	property p_read_ctl;
		regReq.rd && regReq.addr == OFS_TRACK_CTL |=> regRdData ==
			{6'h00, $past(trimCfg.trackingGainAutoscale), $past(trimCfg.trackingForceActive)};
	endproperty
	a_read_ctl: assert property (p_read_ctl) else $error("control read wrong");
	property p_status;
		$past(rst_n) && regReq.rd && regReq.addr == OFS_FAULT_STATUS2 |=>
			regRdData == {$past(converterSaturated, 2), 7'h00};
	endproperty
	a_status: assert property (p_status) else $error("status read wrong");
	property p_period;
		periodValid ##1 (!periodValid && regReq.rd && regReq.addr == OFS_PERIOD_HIGH) |=>
			regRdData == $past(periodActualHighPart, 2);
	endproperty
	a_period: assert property (p_period) else $error("period read wrong");
	property p_uvlo;
		regReq.wr && regReq.addr == OFS_LOOP_LOCKOUT |=>
			trimCfg.undervoltageLockoutLevel == $past(regReq.wrData[4:3]);
	endproperty
	a_uvlo: assert property (p_uvlo) else $error("lockout level wrong");
	property p_slew;
		regReq.wr && regReq.addr == OFS_BRIDGE_SLEW |=>
			{trimCfg.lowSideSlewSelect, trimCfg.highSideSlewSelect} == $past(regReq.wrData[3:0]);
	endproperty
	a_slew: assert property (p_slew) else $error("slew fields wrong");
endmodule
bind haptic_tracking_trim_fault_regs haptic_tracking_trim_fault_regs_props props_inst (
	.clk(clk), .rst_n(rst_n), .regReq(regReq), .regRdData(regRdData),
	.periodValid(periodValid), .periodActualHighPart(periodActualHighPart),
	.periodActualLowPart(periodActualLowPart), .trackingRequest(trackingRequest),
	.trackingErrorLarge(trackingErrorLarge), .driveReversal(driveReversal),
	.converterSaturated(converterSaturated), .trimCfg(trimCfg),
	.trackingActive(trackingActive), .frequencyUpdateEnable(frequencyUpdateEnable),
	.faultIrq(faultIrq)
);

// ### verification/haptic_tracking_trim_fault_regs_tb.sv
// Self-checking bench of the haptic register bank against a register model.
`timescale 1ns/1ns
module haptic_tracking_trim_fault_regs_tb;
	import haptic_regs_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	reg_req_t regReq = '0;
	logic [7:0] regRdData;
	logic periodValid = 1'b0;
	logic [7:0] periodActualHighPart = 8'h00;
	logic [6:0] periodActualLowPart = 7'h00;
	logic trackingRequest = 1'b0;
	logic trackingErrorLarge = 1'b0;
	logic driveReversal = 1'b0;
	logic converterSaturated = 1'b0;
	trim_cfg_t trimCfg;
	logic trackingActive;
	logic frequencyUpdateEnable;
	logic faultIrq;
	int err_count = 0;
	int cmp_count = 0;
	int cycles = 0;
	logic [7:0] mdl [256];
	logic [7:0] rv;
	logic [7:0] lst [18] = '{8'h46, 8'h47, 8'h48, 8'h49, 8'h4c, 8'h5f, 8'h60, 8'h62, 8'h6e,
		8'h81, 8'h82, 8'h83, 8'h84, 8'he7, 8'he8, 8'h4a, 8'h00, 8'hff};
	always #5 clk = ~clk;
	// The capture strobe is a one-cycle pulse, so it drops by itself.
	always @(posedge clk) begin
		if (periodValid) begin
			periodValid <= 1'b0;
		end
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			final_report();
		end
	end
	haptic_tracking_trim_fault_regs haptic_tracking_trim_fault_regs_inst (
		.clk(clk), .rst_n(rst_n), .regReq(regReq), .regRdData(regRdData),
		.periodValid(periodValid), .periodActualHighPart(periodActualHighPart),
		.periodActualLowPart(periodActualLowPart), .trackingRequest(trackingRequest),
		.trackingErrorLarge(trackingErrorLarge), .driveReversal(driveReversal),
		.converterSaturated(converterSaturated), .trimCfg(trimCfg),
		.trackingActive(trackingActive), .frequencyUpdateEnable(frequencyUpdateEnable),
		.faultIrq(faultIrq)
	);
	// ****************************************
	// Model and bus tasks
	// ****************************************
	task automatic final_report();
		if (err_count == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	function automatic logic [7:0] wmask(input logic [7:0] ad);
		case (ad)
			8'h48: return 8'hff;
			8'h49: return 8'h87;
			8'h4c: return 8'h03;
			8'h5f: return 8'h78;
			8'h60: return 8'h0f;
			8'h62: return 8'h0f;
			8'h6e: return 8'h07;
			8'h83: return 8'h80;
			default: return (ad >= 8'h84 && ad <= 8'he7) ? 8'hff : 8'h00;
		endcase
	endfunction
	task automatic mdlReset();
		for (int i = 0; i < 256; i++) begin
			mdl[i] = 8'h00;
		end
		mdl[8'h46] = 8'h21;
		mdl[8'h47] = 8'h4f;
		mdl[8'h48] = 8'h25;
		mdl[8'h49] = 8'h05;
		mdl[8'h4c] = 8'h02;
		mdl[8'h5f] = 8'h08;
		mdl[8'h60] = 8'h0c;
		mdl[8'h62] = 8'h0f;
		mdl[8'h6e] = 8'h01;
	endtask
	task automatic acc(input logic [7:0] ad, input logic [7:0] wd, input logic w);
		@(posedge clk);
		regReq <= '{addr: ad, wrData: wd, wr: w, rd: !w};
		@(posedge clk);
		regReq <= '0;
		#1 rv = regRdData;
	endtask
	task automatic wrReg(input logic [7:0] ad, input logic [7:0] wd);
		acc(ad, wd, 1'b1);
		mdl[ad] = (mdl[ad] & ~wmask(ad)) | (wd & wmask(ad));
		// A pending saturation wins over the clear.
		if (ad == 8'h81 && wd[2] && !converterSaturated) begin
			mdl[8'h81] = 8'h00;
		end
	endtask
	task automatic rdReg(input logic [7:0] ad);
		acc(ad, 8'h00, 1'b0);
		chk(rv, mdl[ad]);
	endtask
	task automatic chkCfg();
		trim_cfg_t e;
		e = {mdl[8'h48], mdl[8'h49][7], mdl[8'h49][2:0], mdl[8'h4c][1:0], mdl[8'h5f][6:3],
			mdl[8'h60][3:0], mdl[8'h62][3:0], mdl[8'h6e][2:0]};
		chk(trimCfg, e);
	endtask
	task automatic satPulse();
		@(posedge clk);
		converterSaturated <= 1'b1;
		@(posedge clk);
		converterSaturated <= 1'b0;
		mdl[8'h81] = 8'h04;
		repeat (2) @(posedge clk);
		#1;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		void'($urandom(37));
		mdlReset();
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		foreach (lst[i]) rdReg(lst[i]);
		chkCfg();
		wrReg(8'h48, 8'h00);
		wrReg(8'h49, 8'h80);
		chkCfg();
		repeat (60) begin
			automatic logic [7:0] ad = lst[$urandom_range(17, 0)];
			automatic logic [7:0] wd = 8'($urandom);
			// Phase bytes only ever get the legal wideband or tracking settings.
			if (ad == 8'h48) begin
				wd = wd[0] ? 8'h25 : 8'h00;
			end
			if (ad == 8'h49) begin
				wd = wd[0] ? 8'h05 : 8'h80;
			end
			wrReg(ad, wd);
			chkCfg();
			rdReg(ad);
		end
		for (int i = 0; i < 100; i++) begin
			wrReg(8'(8'h84 + i), 8'($urandom));
		end
		for (int i = 0; i < 100; i++) begin
			rdReg(8'(8'h84 + i));
		end
		@(posedge clk);
		periodActualHighPart <= 8'($urandom);
		periodActualLowPart <= 7'($urandom);
		rdReg(8'h46);
		@(posedge clk);
		periodValid <= 1'b1;
		mdl[8'h46] = periodActualHighPart;
		mdl[8'h47] = {1'b0, periodActualLowPart};
		rdReg(8'h46);
		rdReg(8'h47);
		wrReg(8'h83, 8'h00);
		satPulse();
		chk(faultIrq, 1'b1);
		rdReg(8'h81);
		rdReg(8'h82);
		wrReg(8'h83, 8'h80);
		// The interrupt is registered, so a mask change shows one cycle after the write.
		@(posedge clk);
		#1 chk(faultIrq, 1'b0);
		wrReg(8'h81, 8'h04);
		rdReg(8'h81);
		satPulse();
		chk(faultIrq, 1'b0);
		rdReg(8'h81);
		rdReg(8'h83);
		wrReg(8'h83, 8'h00);
		@(posedge clk);
		#1 chk(faultIrq, 1'b1);
		@(posedge clk);
		converterSaturated <= 1'b1;
		mdl[8'h82] = 8'h80;
		wrReg(8'h81, 8'h04);
		rdReg(8'h81);
		rdReg(8'h82);
		@(posedge clk);
		converterSaturated <= 1'b0;
		mdl[8'h82] = 8'h00;
		wrReg(8'h81, 8'h04);
		rdReg(8'h81);
		chk(faultIrq, 1'b0);
		for (int i = 0; i < 16; i++) begin
			wrReg(8'h4c, {6'h00, 1'b1, i[0]});
			wrReg(8'h6e, {5'h00, 1'b0, i[1], 1'b1});
			@(posedge clk);
			trackingRequest <= i[2];
			trackingErrorLarge <= i[3];
			driveReversal <= 1'($urandom);
			repeat (2) @(posedge clk);
			#1 chk(trackingActive, i[2] & (!i[3] | i[0]));
			chk(frequencyUpdateEnable, !(i[1] & driveReversal));
		end
		// A second reset in mid-run must bring every field back.
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		mdlReset();
		chkCfg();
		rdReg(8'h84);
		rdReg(8'h47);
		final_report();
	end
endmodule
